// ---- design/cta_pkg.sv ----
package cta_pkg;

    // ==========================================================
    // constants
    localparam logic [15:0] GPR_RST = 16'h0000;
    localparam logic [7:0] ABS8_PAGE = 8'hFF;
    localparam logic [2:0] SP_IDX = 3'h7;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] SMALL_ONE = 16'h0001;
    localparam logic [15:0] SMALL_TWO = 16'h0002;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
    localparam logic [7:0] BCD_LO_FIX = 8'h06;
    localparam logic [7:0] BCD_HI_FIX = 8'h60;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ==========================================================
    // operation and mode codes
    typedef enum logic [4:0] {
        OP_MOVE_LOAD = 5'b00000,
        OP_MOVE_STORE = 5'b00001,
        OP_PUSH = 5'b00010,
        OP_POP = 5'b00011,
        OP_ADD = 5'b00100,
        OP_SUB = 5'b00101,
        OP_ADD_WITH_CARRY = 5'b00110,
        OP_SUBTRACT_WITH_BORROW = 5'b00111,
        OP_INC = 5'b01000,
        OP_DEC = 5'b01001,
        OP_WORD_ADD_SMALL_CONST = 5'b01010,
        OP_WORD_SUB_SMALL_CONST = 5'b01011,
        OP_DECIMAL_ADJUST_AFTER_ADD = 5'b01100,
        OP_DECIMAL_ADJUST_AFTER_SUB = 5'b01101,
        OP_UNSIGNED_BYTE_MULTIPLY = 5'b01110,
        OP_UNSIGNED_WORD_BY_BYTE_DIVIDE = 5'b01111,
        OP_CMP = 5'b10000,
        OP_NEG = 5'b10001
    } cta_op_e;

    typedef enum logic [2:0] {
        MD_REG = 3'b000,
        MD_IND = 3'b001,
        MD_DISP16 = 3'b010,
        MD_ABS8 = 3'b011,
        MD_ABS16 = 3'b100,
        MD_IMM = 3'b101,
        MD_PREDEC = 3'b110,
        MD_POSTINC = 3'b111
    } cta_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MEM = 2'b01
    } cta_state_e;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic h;
        logic n;
        logic z;
        logic v;
        logic c;
    } cta_flags_s;

    typedef struct packed {
        cta_op_e op;
        logic word;
        cta_mode_e mode;
        logic [3:0] dst;
        logic [3:0] src;
        logic [2:0] ptr;
        logic [15:0] imm;
        logic [15:0] disp;
        logic [15:0] aa;
    } cta_req_s;

    typedef struct packed {
        logic req;
        logic we;
        logic word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cta_mem_s;

    typedef struct packed {
        logic [7:0][15:0] gpr;
        cta_flags_s cfr;
        cta_state_e st;
        cta_mem_s mem;
        logic [3:0] ld_dst;
        logic [2:0] ptr;
        logic postinc;
        logic abs8;
        logic [15:0] step;
        logic done;
        logic illegal;
    } cta_state_s;

endpackage : cta_pkg

// ---- design/cta_addsub.sv ----
`timescale 1ns/1ps
module cta_addsub (
    input wire logic [15:0] a,
    input wire logic [15:0] b,
    input wire logic cin,
    input wire logic sub,
    input wire logic word,
    output logic [15:0] sum,
    output cta_pkg::cta_flags_s flg
);
    import cta_pkg::*;

    logic [15:0] be;
    logic ci;
    logic [8:0] s8;
    logic [16:0] s16;

    // ==========================================================
    // subtract as a + ~b + ~borrow, so one carry chain serves both
    always_comb begin
        be = sub ? ~b : b;
        ci = sub ? ~cin : cin;
        s8 = {1'b0, a[7:0]} + {1'b0, be[7:0]} + {8'h00, ci};
        s16 = {1'b0, a} + {1'b0, be} + {16'h0000, ci};
    end

    // flags at the operand size; carry becomes borrow on subtract
    always_comb begin
        if (word) begin
            sum = s16[15:0];
            flg.h = a[12] ^ be[12] ^ s16[12] ^ sub;
            flg.n = s16[15];
            flg.z = (s16[15:0] == 16'h0000);
            flg.v = (a[15] == be[15]) && (s16[15] != a[15]);
            flg.c = s16[16] ^ sub;
        end else begin
            sum = {8'h00, s8[7:0]};
            flg.h = a[4] ^ be[4] ^ s8[4] ^ sub;
            flg.n = s8[7];
            flg.z = (s8[7:0] == 8'h00);
            flg.v = (a[7] == be[7]) && (s8[7] != a[7]);
            flg.c = s8[8] ^ sub;
        end
    end

endmodule : cta_addsub

// ---- design/cta_exec.sv ----
`timescale 1ns/1ps
module cta_exec (
    input wire logic clk,
    input wire logic nrst,
    input wire logic req_valid,
    input cta_pkg::cta_req_s req,
    output logic req_ready,
    output logic done,
    output logic illegal,
    output cta_pkg::cta_mem_s mem,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    output cta_pkg::cta_flags_s flags,
    output logic [7:0][15:0] gpr_view
);
    import cta_pkg::*;

    cta_state_s q;
    cta_state_s n;
    logic acc;
    logic [7:0] a8;
    logic [7:0] b8;
    logic [7:0] rs8;
    logic [15:0] a16;
    logic [15:0] b16;
    logic [15:0] add_a;
    logic [15:0] add_b;
    logic add_cin;
    logic add_sub;
    logic add_word;
    logic [15:0] add_sum;
    cta_flags_s add_flg;

    // ==========================================================
    // byte view of the register file: idx[3] picks the low half
    function automatic logic [7:0] get8(input logic [7:0][15:0] g, input logic [3:0] idx);
        return idx[3] ? g[idx[2:0]][7:0] : g[idx[2:0]][15:8];
    endfunction : get8

    function automatic logic [7:0][15:0] put8(input logic [7:0][15:0] g, input logic [3:0] idx,
                                               input logic [7:0] v);
        logic [7:0][15:0] r;
        r = g;
        if (idx[3]) begin
            r[idx[2:0]][7:0] = v;
        end else begin
            r[idx[2:0]][15:8] = v;
        end
        return r;
    endfunction : put8

    // move flags: n and z from data, v cleared, c and h kept
    function automatic cta_flags_s mvflg(input cta_flags_s f, input logic [15:0] v,
                                          input logic w);
        cta_flags_s r;
        r = f;
        r.n = w ? v[15] : v[7];
        r.z = w ? (v == 16'h0000) : (v[7:0] == BYTE_ZERO);
        r.v = 1'b0;
        return r;
    endfunction : mvflg

    // ==========================================================
    // operand fetch and adder steering
    assign acc = req_valid && (q.st == ST_IDLE);
    assign a8 = get8(q.gpr, req.dst);
    assign rs8 = get8(q.gpr, req.src);
    assign b8 = (req.mode == MD_IMM) ? req.imm[7:0] : rs8;
    assign a16 = q.gpr[req.dst[2:0]];
    assign b16 = q.gpr[req.src[2:0]];

    always_comb begin
        add_a = req.word ? a16 : {8'h00, a8};
        add_b = req.word ? b16 : {8'h00, b8};
        add_cin = 1'b0;
        add_sub = 1'b0;
        add_word = req.word;
        case (req.op)
            OP_SUB, OP_CMP: begin
                add_sub = 1'b1;
            end
            OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW: begin
                add_a = {8'h00, a8};
                add_b = {8'h00, b8};
                add_cin = q.cfr.c;
                add_sub = (req.op == OP_SUBTRACT_WITH_BORROW);
                add_word = 1'b0;
            end
            OP_INC, OP_DEC: begin
                add_a = {8'h00, a8};
                add_b = STEP_BYTE;
                add_sub = (req.op == OP_DEC);
                add_word = 1'b0;
            end
            OP_NEG: begin
                add_a = 16'h0000;
                add_b = {8'h00, a8};
                add_sub = 1'b1;
                add_word = 1'b0;
            end
            default: begin
                add_sub = 1'b0;
            end
        endcase
    end

    cta_addsub u_addsub (
        .a(add_a),
        .b(add_b),
        .cin(add_cin),
        .sub(add_sub),
        .word(add_word),
        .sum(add_sum),
        .flg(add_flg)
    );

    // ==========================================================
    // next-state logic: one request at a time, memory moves wait for ack
    always_comb begin
        logic ismem;
        logic load;
        logic w;
        logic bad;
        logic lofix;
        logic hifix;
        logic [2:0] ptr;
        logic [3:0] reg_i;
        logic [15:0] step;
        logic [15:0] ea;
        logic [15:0] v;
        logic [15:0] quo;
        logic [15:0] rem;
        ismem = 1'b0;
        load = (req.op == OP_MOVE_LOAD) || (req.op == OP_POP);
        w = req.word || (req.op == OP_PUSH) || (req.op == OP_POP);
        bad = 1'b0;
        lofix = q.cfr.h || (a8[3:0] > BCD_DIGIT_MAX);
        hifix = q.cfr.c || (a8 > BCD_BYTE_MAX);
        ptr = (req.op == OP_PUSH || req.op == OP_POP) ? SP_IDX : req.ptr;
        reg_i = load ? req.dst : req.src;
        step = w ? STEP_WORD : STEP_BYTE;
        ea = 16'h0000;
        v = 16'h0000;
        quo = q.gpr[req.dst[2:0]] / {8'h00, rs8};
        rem = q.gpr[req.dst[2:0]] % {8'h00, rs8};
        n = q;
        n.done = 1'b0;
        n.illegal = 1'b0;
        case (q.st)
            ST_IDLE: begin
                if (acc) begin
                    case (req.op)
                        OP_MOVE_LOAD, OP_MOVE_STORE, OP_PUSH, OP_POP: begin
                            case ((req.op == OP_PUSH) ? MD_PREDEC :
                                  (req.op == OP_POP) ? MD_POSTINC : req.mode)
                                MD_REG: v = w ? b16 : {8'h00, rs8};
                                MD_IMM: begin
                                    v = w ? req.imm : {8'h00, req.imm[7:0]};
                                    bad = !load;
                                end
                                MD_IND: ea = q.gpr[ptr];
                                MD_DISP16: ea = q.gpr[ptr] + req.disp;
                                MD_ABS8: begin
                                    ea = {ABS8_PAGE, req.aa[7:0]};
                                    bad = w;
                                end
                                MD_ABS16: ea = req.aa;
                                MD_PREDEC: begin
                                    ea = q.gpr[ptr] - step;
                                    bad = !w && (ptr == SP_IDX);
                                end
                                MD_POSTINC: begin
                                    ea = q.gpr[ptr];
                                    bad = !w && (ptr == SP_IDX);
                                end
                                default: bad = 1'b1;
                            endcase
                            ismem = (req.op == OP_PUSH) || (req.op == OP_POP) ||
                                    !(req.mode == MD_REG || req.mode == MD_IMM);
                            if (bad) begin
                                n.illegal = 1'b1;
                            end else if (ismem) begin
                                n.st = ST_MEM;
                                n.mem.req = 1'b1;
                                n.mem.we = !load;
                                n.mem.word = w;
                                n.mem.addr = {ea[15:1], ea[0] & !w};
                                n.mem.wdata = w ? q.gpr[req.src[2:0]] : {8'h00, rs8};
                                n.ld_dst = reg_i;
                                n.ptr = ptr;
                                n.step = step;
                                n.abs8 = (req.mode == MD_ABS8) && (req.op != OP_PUSH) &&
                                         (req.op != OP_POP);
                                n.postinc = (req.op == OP_POP) ||
                                            (req.mode == MD_POSTINC && req.op != OP_PUSH);
                                if ((req.op == OP_PUSH) ||
                                    (req.mode == MD_PREDEC && req.op != OP_POP)) begin
                                    n.gpr[ptr] = ea;
                                end
                                if (!load) begin
                                    n.cfr = mvflg(q.cfr, n.mem.wdata, w);
                                end
                            end else begin
                                if (w) begin
                                    n.gpr[req.dst[2:0]] = v;
                                end else begin
                                    n.gpr = put8(q.gpr, req.dst, v[7:0]);
                                end
                                n.cfr = mvflg(q.cfr, v, w);
                                n.done = 1'b1;
                            end
                        end
                        OP_ADD, OP_SUB, OP_CMP, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW,
                        OP_NEG: begin
                            // word immediates and immediate subtract are refused
                            bad = (req.mode == MD_IMM) &&
                                  (req.word || req.op == OP_SUB);
                            bad = bad || (req.mode != MD_IMM && req.mode != MD_REG);
                            if (bad) begin
                                n.illegal = 1'b1;
                            end else begin
                                n.cfr = add_flg;
                                if (req.op != OP_CMP) begin
                                    if (add_word) begin
                                        n.gpr[req.dst[2:0]] = add_sum;
                                    end else begin
                                        n.gpr = put8(q.gpr, req.dst, add_sum[7:0]);
                                    end
                                end
                                n.done = 1'b1;
                            end
                        end
                        OP_INC, OP_DEC: begin
                            n.gpr = put8(q.gpr, req.dst, add_sum[7:0]);
                            n.cfr.n = add_flg.n;
                            n.cfr.z = add_flg.z;
                            n.cfr.v = add_flg.v;
                            n.done = 1'b1;
                        end
                        OP_WORD_ADD_SMALL_CONST, OP_WORD_SUB_SMALL_CONST: begin
                            if (req.imm != SMALL_ONE && req.imm != SMALL_TWO) begin
                                n.illegal = 1'b1;
                            end else begin
                                n.gpr[req.dst[2:0]] = (req.op == OP_WORD_ADD_SMALL_CONST) ?
                                    a16 + req.imm : a16 - req.imm;
                                n.done = 1'b1;
                            end
                        end
                        OP_DECIMAL_ADJUST_AFTER_ADD, OP_DECIMAL_ADJUST_AFTER_SUB: begin
                            if (req.op == OP_DECIMAL_ADJUST_AFTER_ADD) begin
                                v[7:0] = a8 + (lofix ? BCD_LO_FIX : BYTE_ZERO) +
                                         (hifix ? BCD_HI_FIX : BYTE_ZERO);
                                n.cfr.c = hifix;
                            end else begin
                                v[7:0] = a8 - (q.cfr.h ? BCD_LO_FIX : BYTE_ZERO) -
                                         (q.cfr.c ? BCD_HI_FIX : BYTE_ZERO);
                            end
                            n.gpr = put8(q.gpr, req.dst, v[7:0]);
                            n.cfr.n = v[7];
                            n.cfr.z = (v[7:0] == BYTE_ZERO);
                            n.done = 1'b1;
                        end
                        OP_UNSIGNED_BYTE_MULTIPLY: begin
                            n.gpr[req.dst[2:0]] = {8'h00, a16[7:0]} * {8'h00, rs8};
                            n.done = 1'b1;
                        end
                        OP_UNSIGNED_WORD_BY_BYTE_DIVIDE: begin
                            // a zero divisor leaves the register alone and raises z
                            if (rs8 != BYTE_ZERO) begin
                                n.gpr[req.dst[2:0]] = {rem[7:0], quo[7:0]};
                            end
                            n.cfr.n = (rs8 != BYTE_ZERO) && quo[7];
                            n.cfr.z = (rs8 == BYTE_ZERO) || (quo[7:0] == BYTE_ZERO);
                            n.done = 1'b1;
                        end
                        default: n.illegal = 1'b1;
                    endcase
                end
            end
            ST_MEM: begin
                if (mem_ack) begin
                    n.st = ST_IDLE;
                    n.mem.req = 1'b0;
                    n.done = 1'b1;
                    if (q.postinc) begin
                        n.gpr[q.ptr] = q.gpr[q.ptr] + q.step;
                    end
                    // a load into the pointer itself wins over the increment
                    if (!q.mem.we) begin
                        v = q.mem.word ? mem_rdata : {8'h00, mem_rdata[7:0]};
                        if (q.mem.word) begin
                            n.gpr[q.ld_dst[2:0]] = v;
                        end else begin
                            n.gpr = put8(n.gpr, q.ld_dst, v[7:0]);
                        end
                        n.cfr = mvflg(q.cfr, v, q.mem.word);
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign req_ready = (q.st == ST_IDLE);
    assign done = q.done;
    assign illegal = q.illegal;
    assign mem = q.mem;
    assign flags = q.cfr;
    assign gpr_view = q.gpr;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_inc_result: assert property (acc && req.op == OP_INC |=>
        get8(q.gpr, $past(req.dst)) == 8'($past(a8) + 8'h01))
        else $error("increment result wrong");
    chk_neg_result: assert property (acc && req.op == OP_NEG |=>
        get8(q.gpr, $past(req.dst)) == 8'(8'h00 - $past(a8)) && done)
        else $error("negate result wrong");
    chk_mul_product: assert property (acc && req.op == OP_UNSIGNED_BYTE_MULTIPLY |=>
        q.gpr[$past(req.dst[2:0])] == $past(a16[7:0]) * $past(rs8))
        else $error("multiply product wrong");
    chk_cmp_noreg: assert property (acc && req.op == OP_CMP |=>
        q.gpr == $past(q.gpr))
        else $error("compare wrote a register");
    chk_abs8_upper: assert property (mem.req && q.abs8 |->
        mem.addr[15:8] == ABS8_PAGE)
        else $error("abs8 page not all ones");
    chk_word_even: assert property (mem.req && mem.word |-> !mem.addr[0])
        else $error("word access at odd address");
    chk_push_predec: assert property (acc && req.op == OP_PUSH |=>
        mem.req && mem.we && mem.addr == 16'($past(q.gpr[SP_IDX]) - STEP_WORD)
        && q.gpr[SP_IDX] == mem.addr)
        else $error("push address wrong");
    chk_postinc_step: assert property (q.st == ST_MEM && mem_ack && q.postinc |=>
        q.gpr[$past(q.ptr)] == 16'($past(q.gpr[q.ptr]) + $past(q.step))
        || $past(q.ld_dst[2:0]) == $past(q.ptr))
        else $error("post-increment step wrong");
    chk_subimm_refused: assert property (acc && req.op == OP_SUB &&
        req.mode == MD_IMM |=> illegal && !done ##1 (!illegal || $past(acc)))
        else $error("immediate subtract accepted");
    chk_byte_sp_refused: assert property (acc && !req.word && req.ptr == SP_IDX &&
        (req.op == OP_MOVE_LOAD || req.op == OP_MOVE_STORE) &&
        (req.mode == MD_POSTINC || req.mode == MD_PREDEC) |=> illegal && !mem.req)
        else $error("byte auto-mode on register seven accepted");

endmodule : cta_exec

// ---- tb/cta_mem_model.sv ----
`timescale 1ns/1ps
module cta_mem_model (
    input wire logic clk,
    input cta_pkg::cta_mem_s mem,
    output logic mem_ack = 1'b0,
    output logic [15:0] mem_rdata = 16'h5A5A
);
    import cta_pkg::*;
    logic [7:0] mb [0:65535];
    logic [15:0] a;
    int wait_cnt = 0;
    logic take;
    // unwritten bytes read back as a fixed pattern
    initial foreach (mb[i]) mb[i] = 8'hA5;
    // ==========================================
    // data memory with a random wait of zero to two cycles
    always @(posedge clk) begin
        a = {mem.addr[15:1], 1'b0};
        take = mem.req && !mem_ack && (wait_cnt == 0);
        if (mem.req && !mem_ack && wait_cnt > 0) wait_cnt--;
        mem_ack <= take;
        if (take) begin
            wait_cnt = $urandom_range(2);
            if (mem.we && mem.word) {mb[a], mb[a + 1]} = mem.wdata;
            else if (mem.we) mb[mem.addr] = mem.wdata[7:0];
        end
        // idle bus toggles so stale data never looks valid
        if (take && !mem.we) mem_rdata <= mem.word ? {mb[a], mb[a + 1]} :
            {~mb[mem.addr], mb[mem.addr]};
        else mem_rdata <= ~mem_rdata;
    end
endmodule : cta_mem_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`define CHK(x, y) begin tests_run++; if ((x) !== (y)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, x, y); end end
module testbench;
    import cta_pkg::*;
    typedef struct packed {
        logic il; logic [2:0] r; logic [15:0] v; logic [4:0] f; logic [4:0] m;
    } cta_note_s;
    localparam logic [4:0] M_NZV = 5'h0E, M_NZVC = 5'h0F;
    logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0;
    cta_req_s req = '0;
    logic req_ready, done, illegal, mem_ack;
    cta_mem_s mem;
    logic [15:0] mem_rdata, a, b, s, r1v;
    cta_flags_s flags;
    logic [7:0][15:0] gpr_view;
    logic [4:0] f;
    logic [7:0] x3 = 8'h00;
    int fail_count = 0, tests_run = 0, k;
    cta_note_s notes[$];
    cta_note_s n;
    cta_req_s rq;
    cta_exec dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .illegal(illegal), .mem(mem),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .flags(flags), .gpr_view(gpr_view));
    cta_mem_model mem_model (.clk(clk), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    initial forever #4 clk = ~clk;
    // ==========================================
    // helpers: request builder, reference adder, driver, verdict
    function automatic cta_req_s mk(cta_op_e o, logic wd, cta_mode_e md, logic [3:0] d, sr,
        logic [2:0] p = 3'h0, logic [15:0] im = 16'h0000);
        mk = '{op: o, word: wd, mode: md, dst: d, src: sr, ptr: p, imm: im, disp: 16'h0000, aa: im};
    endfunction : mk
    function automatic logic [4:0] alu(input logic [15:0] x, y, input logic sb, ci, wd,
        output logic [15:0] r);
        logic [16:0] t;
        int m;
        m = wd ? 15 : 7;
        t = sb ? {1'b0, x} - y - ci : {1'b0, x} + y + ci;
        r = t[15:0];
        alu = {1'b0, r[m], wd ? r == 16'h0000 : r[7:0] == 8'h00,
            (x[m] ^ r[m]) & ~(x[m] ^ y[m] ^ sb), t[m + 1]};
    endfunction : alu
    task automatic stop_test(input bit to);
        if (to) fail_count++;
        if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    // request held until the edge where ready is seen high; result noted for the monitor
    task automatic issue(cta_req_s q, logic [2:0] r, logic [15:0] v, logic [4:0] ef,
        logic [4:0] m, logic il = 1'b0);
        int i;
        notes.push_back('{il, r, v, ef, m});
        req_valid <= 1'b1;
        req <= q;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            if (req_ready === 1'b1) break;
        end
        if (i == 40) stop_test(1'b1);
        else @(posedge clk);
    endtask : issue
    task automatic ldw(logic [2:0] r, logic [15:0] v);
        issue(mk(OP_MOVE_LOAD, 1, MD_IMM, {1'b0, r}, 0, 0, v), r, v,
            {1'b0, v[15], v == 16'h0000, 2'b00}, M_NZV);
    endtask : ldw
    // ==========================================
    // monitor: oldest note against each completion or refusal
    always @(posedge clk) begin
        if (mem.req && mem.word) `CHK(mem.addr[0], 1'b0)
        if (done || illegal) begin
            n = notes.pop_front();
            `CHK({illegal, gpr_view[n.r]}, {n.il, n.v})
            `CHK(flags & n.m, n.f & n.m)
        end
    end
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(56534));
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            a = $urandom;
            b = $urandom;
            ldw(1, a);
            ldw(2, b);
            f = alu(a, b, i[0], 0, 1, r1v);
            issue(mk(i[0] ? OP_SUB : OP_ADD, 1, MD_REG, 1, 2), 1, r1v, f, M_NZVC);
        end
        f = alu(r1v, b, 1, 0, 1, s);
        issue(mk(OP_CMP, 1, MD_REG, 1, 2), 1, r1v, f, M_NZVC);
        issue(mk(OP_SUB, 0, MD_IMM, 4'h9, 0, 0, 16'h0003), 1, r1v, 0, 0, 1);
        issue(mk(OP_ADD, 1, MD_IMM, 1, 0, 0, 16'h0003), 1, r1v, 0, 0, 1);
        issue(mk(OP_CMP, 1, MD_IMM, 1, 0, 0, 16'h0003), 1, r1v, 0, 0, 1);
        issue(mk(OP_MOVE_LOAD, 1, MD_ABS8, 1, 0, 0, 16'h0034), 1, r1v, 0, 0, 1);
        issue(mk(OP_MOVE_LOAD, 0, MD_PREDEC, 4'h9, 0, 7), 1, r1v, 0, 0, 1);
        issue(mk(OP_WORD_ADD_SMALL_CONST, 1, MD_IMM, 1, 0, 0, 16'h0003), 1, r1v, 0, 0, 1);
        for (int i = 0; i < 4; i++) begin
            r1v = i[1] ? r1v - (i[0] + 1) : r1v + (i[0] + 1);
            issue(mk(i[1] ? OP_WORD_SUB_SMALL_CONST : OP_WORD_ADD_SMALL_CONST, 1, MD_IMM,
                1, 0, 0, i[0] + 1), 1, r1v, 0, 0);
        end
        for (int i = 0; i < 4; i++) begin
            b = $urandom_range(255);
            f = alu({8'h00, x3}, b, i[0], f[0], 0, s);
            issue(mk(i[0] ? OP_SUBTRACT_WITH_BORROW : OP_ADD_WITH_CARRY, 0, MD_IMM, 4'hB, 0,
                0, b), 3, {8'h00, s[7:0]}, f, M_NZVC);
            x3 = s[7:0];
        end
        issue(mk(OP_MOVE_LOAD, 0, MD_IMM, 4'hB, 0, 0, 16'h00FF), 3, 16'h00FF, 5'h08, M_NZV);
        issue(mk(OP_INC, 0, MD_REG, 4'hB, 0), 3, 16'h0000, {4'h2, f[0]}, M_NZVC);
        issue(mk(OP_DEC, 0, MD_REG, 4'hB, 0), 3, 16'h00FF, {4'h4, f[0]}, M_NZVC);
        ldw(3, 16'h0015);
        ldw(4, 16'h0027);
        issue(mk(OP_ADD, 0, MD_REG, 4'hB, 4'hC), 3, 16'h003C, 5'h00, 5'h1F);
        issue(mk(OP_DECIMAL_ADJUST_AFTER_ADD, 0, MD_REG, 4'hB, 0), 3, 16'h0042, 0, 5'h0D);
        issue(mk(OP_SUB, 0, MD_REG, 4'hB, 4'hC), 3, 16'h001B, 5'h10, 5'h1F);
        issue(mk(OP_DECIMAL_ADJUST_AFTER_SUB, 0, MD_REG, 4'hB, 0), 3, 16'h0015, 0, 5'h0D);
        ldw(5, 16'h00C8);
        issue(mk(OP_UNSIGNED_BYTE_MULTIPLY, 0, MD_REG, 4'h5, 4'hC), 5, 16'h1E78, 0, 0);
        ldw(5, 16'h1E7B);
        issue(mk(OP_UNSIGNED_WORD_BY_BYTE_DIVIDE, 0, MD_REG, 4'h5, 4'hC), 5, 16'h03C8,
            5'h08, 5'h0C);
        f = alu(16'h0000, 16'h0027, 1, 0, 0, s);
        issue(mk(OP_NEG, 0, MD_REG, 4'hC, 0), 4, 16'h00D9, f, M_NZVC);
        ldw(7, 16'h0100);
        issue(mk(OP_PUSH, 1, MD_REG, 1, 1), 7, 16'h00FE, 0, 0);
        issue(mk(OP_POP, 1, MD_REG, 6, 6), 6, r1v, 0, 0);
        issue(mk(OP_MOVE_STORE, 1, MD_REG, 0, 7), 0, 16'h0100, 0, M_NZV);
        ldw(2, 16'h0200);
        issue(mk(OP_MOVE_LOAD, 0, MD_POSTINC, 4'h8, 0, 2), 0, 16'h01A5, 5'h08, M_NZV);
        issue(mk(OP_MOVE_STORE, 1, MD_REG, 0, 2), 0, 16'h0201, 0, M_NZV);
        issue(mk(OP_MOVE_LOAD, 1, MD_POSTINC, 0, 0, 2), 0, 16'hA5A5, 5'h08, M_NZV);
        issue(mk(OP_MOVE_STORE, 1, MD_REG, 0, 2), 0, 16'h0203, 0, M_NZV);
        issue(mk(OP_MOVE_STORE, 0, MD_ABS8, 0, 4'hC, 0, 16'h0034), 4, 16'h00D9, 0, 0);
        issue(mk(OP_MOVE_LOAD, 0, MD_ABS16, 4'hB, 0, 0, 16'hFF34), 3, 16'h00D9, 5'h08, M_NZV);
        issue(mk(OP_MOVE_STORE, 1, MD_IND, 0, 1, 2), 1, r1v, 0, 0);
        issue(mk(OP_MOVE_LOAD, 1, MD_ABS16, 6, 0, 0, 16'h0202), 6, r1v, 0, 0);
        rq = mk(OP_MOVE_LOAD, 1, MD_DISP16, 4, 0, 2);
        rq.disp = 16'hFFFF;
        issue(rq, 4, r1v, 0, 0);
        req_valid <= 1'b0;
        for (k = 0; k < 50 && notes.size() != 0; k++) @(posedge clk);
        stop_test(notes.size() != 0);
    end
endmodule : testbench
